/* logic/idr_pkg.sv */
// Constants, field layouts and carrier types for the illumination register bank
//
// How it works
// - Step code 0..3 selects LED unit 5, 3.75, 2.5 or 1.25 mA.
// - On current is (bias plus modulation) times step; off current is bias times step.
// - Modulation current is a 5-bit field at 19-15, resets to zero.
// - Bit 14 enables the driver output; zero keeps it powered down.
// - Supplementary duty is base duty times (scale plus one) over 64.
// - Status bit 23 flags a duty cycle the quad period cannot hold.
// - Status bit 22 flags a quad period count that is too small.
// - Status register resets to c32 with both flags clear.
// - Bias current is a 4-bit field at bits 7-4, in step units.
// - Base duty percent is the duty field times 100 over 64.
package idr_pkg;

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;

  // Register offsets
  localparam logic [7:0] OFF_BIAS = 8'h39;
  localparam logic [7:0] OFF_DRV = 8'h3b;
  localparam logic [7:0] OFF_SCALE = 8'h4f;
  localparam logic [7:0] OFF_TSTAT = 8'h50;
  localparam logic [7:0] OFF_DUTY = 8'h5c;
  localparam logic [7:0] OFF_QUAD = 8'h70;

  // Field positions
  localparam int BIAS_LSB = 4;
  localparam int DRV_STEP_LSB = 20;
  localparam int DRV_MOD_LSB = 15;
  localparam int DRV_EN_BIT = 14;
  localparam int SCALE_LSB = 0;
  localparam int DUTY_LSB = 18;
  localparam int QUAD_LSB = 0;
  localparam int TSTAT_DUTY_ERR_BIT = 23;
  localparam int TSTAT_QUAD_ERR_BIT = 22;
  localparam int TSTAT_RW_W = 22;

  // Reset values
  localparam logic [3:0] RST_BIAS = 4'h0;
  localparam logic [1:0] RST_STEP = 2'h0;
  localparam logic [4:0] RST_MOD = 5'h00;
  localparam logic RST_EN = 1'b0;
  localparam logic [5:0] RST_SCALE = 6'h3f;
  localparam logic [21:0] RST_TSTAT = 22'h000c32;
  localparam logic [5:0] RST_DUTY = 6'h0d;
  localparam logic [15:0] RST_QUAD = 16'h0100;

  // Step sizes in microamps: 5000, 3750, 2500, 1250
  localparam logic [12:0] STEP0_UA = 13'h1388;
  localparam logic [12:0] STEP1_UA = 13'h0ea6;
  localparam logic [12:0] STEP2_UA = 13'h09c4;
  localparam logic [12:0] STEP3_UA = 13'h04e2;

  // Duty cycle denominator is 64, applied as a shift
  localparam int DUTY_SHIFT = 6;
  // Hundredths of a percent per duty unit times 4 (10000 / 64 = 625 / 4)
  localparam logic [9:0] PCT_X100_MUL = 10'h271;
  localparam int PCT_X100_SHIFT = 2;

  // Current output width in microamps
  localparam int UA_W = 18;

  // Driver configuration as one carrier
  typedef struct packed {
    logic [1:0] step;
    logic [4:0] mod;
    logic en;
  } idr_drv_cfg_s;

  // Timing failure flags
  typedef struct packed {
    logic duty_cycle_fit_error;
    logic quad_period_too_low_error;
  } idr_status_s;

endpackage

/* logic/idr_current_calc.sv */
// Scales a current count by the selected LED step size
`timescale 1ns/10ps
module idr_current_calc #(
  parameter int CNT_W = 6
) (
  // Count in step units and step code
  input wire logic [CNT_W-1:0] count,
  input wire logic [1:0] step_code,
  // Resulting current in microamps
  output logic [idr_pkg::UA_W-1:0] current_ua
);
  import idr_pkg::*;

  // Product must be at least as wide as the output slice, and the largest count must fit it
  initial begin
    if (CNT_W < 5 || CNT_W > 6) begin
      $error("idr_current_calc: CNT_W out of range");
    end
  end

  wire logic [12:0] step_ua;
  wire logic [CNT_W+12:0] product;

  // Step decode
  assign step_ua = (step_code == 2'h0) ? STEP0_UA :
                   (step_code == 2'h1) ? STEP1_UA :
                   (step_code == 2'h2) ? STEP2_UA : STEP3_UA;
  // Product fits 18 bits for counts up to 46 at 5 mA
  assign product = count * step_ua;
  assign current_ua = product[UA_W-1:0];

endmodule

/* logic/idr_timing_check.sv */
// Duty cycle scaling and quad period failure checks
`timescale 1ns/10ps
module idr_timing_check #(
  parameter int QUAD_W = 16,
  parameter logic [15:0] QUAD_MIN = 16'h0040,
  parameter logic [15:0] DEAD_MIN = 16'h0010
) (
  // Programmed settings
  input wire logic [5:0] duty,
  input wire logic [5:0] scale,
  input wire logic [QUAD_W-1:0] quad,
  // Derived values and flags
  output logic [11:0] sup_duty,
  output logic [13:0] base_pct_x100,
  output idr_pkg::idr_status_s status
);
  import idr_pkg::*;

  initial begin
    if (QUAD_W != 16) begin
      $error("idr_timing_check: QUAD_W must be 16");
    end
  end

  wire logic [6:0] scale_p1;
  wire logic [12:0] sup_prod;
  wire logic [15:0] pct_prod;
  wire logic [21:0] win_prod;
  wire logic [15:0] win_cnt;
  wire logic [15:0] dead_cnt;

  // Supplementary duty in 1/4096 units of a period
  assign scale_p1 = {1'b0, scale} + 7'h01;
  assign sup_prod = duty * scale_p1;
  assign sup_duty = sup_prod[11:0];
  // Base duty in hundredths of a percent
  assign pct_prod = duty * PCT_X100_MUL;
  assign base_pct_x100 = 14'(pct_prod >> PCT_X100_SHIFT);
  // Integration window length within one quad period
  assign win_prod = quad * duty;
  assign win_cnt = 16'(win_prod >> DUTY_SHIFT);
  assign dead_cnt = quad - win_cnt;
  // Flags are pure functions of the settings, never latched
  assign status.duty_cycle_fit_error = (dead_cnt < DEAD_MIN);
  assign status.quad_period_too_low_error = (quad < QUAD_MIN);

endmodule

/* logic/idr_regs.sv */
// Illumination driver and integration timing register bank
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module idr_regs #(
  parameter logic [15:0] QUAD_MIN = 16'h0040,
  parameter logic [15:0] DEAD_MIN = 16'h0010
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [idr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [idr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [idr_pkg::DATA_W-1:0] reg_rdata,
  // Modulation gate from the timing generator, same clock
  input wire logic mod_gate,
  // Driver configuration and currents
  output idr_pkg::idr_drv_cfg_s drv_cfg,
  output logic [idr_pkg::UA_W-1:0] led_on_current_ua,
  output logic [idr_pkg::UA_W-1:0] led_off_current_ua,
  output logic [idr_pkg::UA_W-1:0] illum_driver_output,
  output logic led_driver_enable,
  // Integration timing
  output logic [5:0] integration_duty_cycle,
  output logic [11:0] supplementary_duty,
  output logic [13:0] base_duty_pct_x100,
  output logic [15:0] quad_period_count,
  output idr_pkg::idr_status_s timing_status
);
  import idr_pkg::*;

  // Limits must leave room for a non-empty window
  initial begin
    if (QUAD_MIN == 16'h0000 || DEAD_MIN > QUAD_MIN) begin
      $error("idr_regs: QUAD_MIN and DEAD_MIN inconsistent");
    end
  end

  // Stored fields
  logic [3:0] bias_reg;
  logic [3:0] bias_next;
  logic [1:0] step_reg;
  logic [1:0] step_next;
  logic [4:0] mod_reg;
  logic [4:0] mod_next;
  logic en_reg;
  logic en_next;
  logic [5:0] scale_reg;
  logic [5:0] scale_next;
  logic [21:0] tstat_reg;
  logic [21:0] tstat_next;
  logic [5:0] duty_reg;
  logic [5:0] duty_next;
  logic [15:0] quad_reg;
  logic [15:0] quad_next;

  // Read path
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Output registers
  logic [UA_W-1:0] on_ua_reg;
  logic [UA_W-1:0] off_ua_reg;
  logic [UA_W-1:0] drive_ua_reg;
  logic [UA_W-1:0] drive_ua_next;
  logic [11:0] sup_reg;
  logic [13:0] pct_reg;
  idr_status_s status_reg;

  // Address decode
  wire logic hit_bias;
  wire logic hit_drv;
  wire logic hit_scale;
  wire logic hit_tstat;
  wire logic hit_duty;
  wire logic hit_quad;

  assign hit_bias = (reg_addr == OFF_BIAS);
  assign hit_drv = (reg_addr == OFF_DRV);
  assign hit_scale = (reg_addr == OFF_SCALE);
  assign hit_tstat = (reg_addr == OFF_TSTAT);
  assign hit_duty = (reg_addr == OFF_DUTY);
  assign hit_quad = (reg_addr == OFF_QUAD);

  // Write strobes per register
  wire logic wr_bias;
  wire logic wr_drv;
  wire logic wr_scale;
  wire logic wr_tstat;
  wire logic wr_duty;
  wire logic wr_quad;

  assign wr_bias = reg_wr & hit_bias;
  assign wr_drv = reg_wr & hit_drv;
  assign wr_scale = reg_wr & hit_scale;
  assign wr_tstat = reg_wr & hit_tstat;
  assign wr_duty = reg_wr & hit_duty;
  assign wr_quad = reg_wr & hit_quad;

  // Next values: only defined fields are stored, reserved bits are dropped
  assign bias_next = wr_bias ? reg_wdata[BIAS_LSB +: 4] : bias_reg;
  assign step_next = wr_drv ? reg_wdata[DRV_STEP_LSB +: 2] : step_reg;
  assign mod_next = wr_drv ? reg_wdata[DRV_MOD_LSB +: 5] : mod_reg;
  assign en_next = wr_drv ? reg_wdata[DRV_EN_BIT] : en_reg;
  assign scale_next = wr_scale ? reg_wdata[SCALE_LSB +: 6] : scale_reg;
  // Fixed-pattern bits are stored as written so software sees its value
  assign tstat_next = wr_tstat ? reg_wdata[TSTAT_RW_W-1:0] : tstat_reg;
  assign duty_next = wr_duty ? reg_wdata[DUTY_LSB +: 6] : duty_reg;
  assign quad_next = wr_quad ? reg_wdata[QUAD_LSB +: 16] : quad_reg;

  // Configuration fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_reg <= RST_BIAS;
      step_reg <= RST_STEP;
      mod_reg <= RST_MOD;
      en_reg <= RST_EN;
      scale_reg <= RST_SCALE;
    end else begin
      bias_reg <= bias_next;
      step_reg <= step_next;
      mod_reg <= mod_next;
      en_reg <= en_next;
      scale_reg <= scale_next;
    end
  end

  // Timing setup fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tstat_reg <= RST_TSTAT;
      duty_reg <= RST_DUTY;
      quad_reg <= RST_QUAD;
    end else begin
      tstat_reg <= tstat_next;
      duty_reg <= duty_next;
      quad_reg <= quad_next;
    end
  end

  // Current computation for both driver states
  wire logic [5:0] on_count;
  wire logic [5:0] off_count;
  wire logic [UA_W-1:0] on_ua;
  wire logic [UA_W-1:0] off_ua;

  assign on_count = {2'h0, bias_reg} + {1'b0, mod_reg};
  assign off_count = {2'h0, bias_reg};

  idr_current_calc #(
    .CNT_W(6)
  ) u_on_calc (
    .count(on_count),
    .step_code(step_reg),
    .current_ua(on_ua)
  );

  idr_current_calc #(
    .CNT_W(6)
  ) u_off_calc (
    .count(off_count),
    .step_code(step_reg),
    .current_ua(off_ua)
  );

  // Duty scaling and failure checks
  wire logic [11:0] sup_duty;
  wire logic [13:0] base_pct;
  idr_status_s status_now;

  idr_timing_check #(
    .QUAD_W(16),
    .QUAD_MIN(QUAD_MIN),
    .DEAD_MIN(DEAD_MIN)
  ) u_timing (
    .duty(duty_reg),
    .scale(scale_reg),
    .quad(quad_reg),
    .sup_duty(sup_duty),
    .base_pct_x100(base_pct),
    .status(status_now)
  );

  // Driver pin current: powered down draws nothing, otherwise on or off level
  assign drive_ua_next = !en_reg ? '0 :
                         (mod_gate ? on_ua : off_ua);

  // Registered outputs; one cycle behind the settings
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_ua_reg <= '0;
      off_ua_reg <= '0;
      drive_ua_reg <= '0;
      sup_reg <= '0;
      pct_reg <= '0;
      status_reg <= '0;
    end else begin
      on_ua_reg <= on_ua;
      off_ua_reg <= off_ua;
      drive_ua_reg <= drive_ua_next;
      sup_reg <= sup_duty;
      pct_reg <= base_pct;
      status_reg <= status_now;
    end
  end

  // Read words; reserved and write-only bits read zero
  wire logic [DATA_W-1:0] rd_bias;
  wire logic [DATA_W-1:0] rd_drv;
  wire logic [DATA_W-1:0] rd_scale;
  wire logic [DATA_W-1:0] rd_tstat;
  wire logic [DATA_W-1:0] rd_duty;
  wire logic [DATA_W-1:0] rd_quad;

  assign rd_bias = DATA_W'({bias_reg, 4'h0});
  assign rd_drv = {2'h0, step_reg, mod_reg, en_reg, 14'h0000};
  assign rd_scale = DATA_W'(scale_reg);
  // Flags come straight from the checker so a read follows the last write
  assign rd_tstat = {status_now.duty_cycle_fit_error,
                     status_now.quad_period_too_low_error,
                     tstat_reg};
  assign rd_duty = {duty_reg, 18'h00000};
  assign rd_quad = DATA_W'(quad_reg);

  // Unmapped addresses answer zero, never stall the master
  assign rdata_next = !reg_rd ? '0 :
                      hit_bias ? rd_bias :
                      hit_drv ? rd_drv :
                      hit_scale ? rd_scale :
                      hit_tstat ? rd_tstat :
                      hit_duty ? rd_duty :
                      hit_quad ? rd_quad : '0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Output wiring
  assign reg_rdata = rdata_reg;
  assign drv_cfg.step = step_reg;
  assign drv_cfg.mod = mod_reg;
  assign drv_cfg.en = en_reg;
  assign led_on_current_ua = on_ua_reg;
  assign led_off_current_ua = off_ua_reg;
  assign illum_driver_output = drive_ua_reg;
  assign led_driver_enable = en_reg;
  assign integration_duty_cycle = duty_reg;
  assign supplementary_duty = sup_reg;
  assign base_duty_pct_x100 = pct_reg;
  assign quad_period_count = quad_reg;
  assign timing_status = status_reg;

endmodule

/* verification/idr_properties.sv */
// Port-level checker for the illumination register bank
`timescale 1ns/10ps
module idr_properties import idr_pkg::*; #(
  parameter logic [15:0] QUAD_MIN = 16'h0040,
  parameter logic [15:0] DEAD_MIN = 16'h0010
) (
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [idr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [idr_pkg::DATA_W-1:0] reg_rdata,
  // Driver side
  input wire logic mod_gate,
  input wire idr_pkg::idr_drv_cfg_s drv_cfg,
  input wire logic [idr_pkg::UA_W-1:0] led_on_current_ua,
  input wire logic [idr_pkg::UA_W-1:0] led_off_current_ua,
  input wire logic [idr_pkg::UA_W-1:0] illum_driver_output,
  // Timing side
  input wire logic [5:0] integration_duty_cycle,
  input wire logic [13:0] base_duty_pct_x100,
  input wire logic [15:0] quad_period_count,
  input wire idr_pkg::idr_status_s timing_status
);
  logic [1:0] up_cnt;
  logic up_ok;
  logic [17:0] mod_ua;
  logic [21:0] quad_prod;
  logic [15:0] dead_cnt;

  // Unit current, 5 mA falling by 1.25 mA per code
  function automatic logic [17:0] step_ua(input logic [1:0] c);
    return 18'd5000 - 18'd1250 * 18'(c);
  endfunction

  // Registered outputs lag the settings, so skip the first edges after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  assign up_ok = up_cnt == 2'h3;
  assign mod_ua = 18'(drv_cfg.mod) * step_ua(drv_cfg.step);
  assign quad_prod = 22'(quad_period_count) * 22'(integration_duty_cycle);
  assign dead_cnt = quad_period_count - quad_prod[21:6];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Settings held long enough for the registered results
  sequence s_drv_held;
    (up_ok && $stable(drv_cfg)) [*2];
  endsequence
  sequence s_timing_held;
    (up_ok && $stable({quad_period_count, integration_duty_cycle})) [*2];
  endsequence

  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 24'h0)
    else $error("read data not zero outside a read");
  AST_DRV_RSV: assert property (reg_rd && reg_addr == OFF_DRV |=>
    reg_rdata[23:22] == 2'h0 && reg_rdata[13:0] == 14'h0) else $error("driver spare bits set");
  AST_SCALE_RSV: assert property (reg_rd && reg_addr == OFF_SCALE |=>
    reg_rdata[23:6] == 18'h0) else $error("scale upper bits set");
  AST_EN_OUT: assert property (!drv_cfg.en ##1 !drv_cfg.en |->
    illum_driver_output == 18'h0) else $error("driver output while disabled");
  AST_ON_CUR: assert property (drv_cfg.en && mod_gate ##1 $stable(led_on_current_ua) |->
    illum_driver_output == led_on_current_ua) else $error("on current not driven");
  AST_OFF_CUR: assert property (drv_cfg.en && !mod_gate ##1 $stable(led_off_current_ua) |->
    illum_driver_output == led_off_current_ua) else $error("off current not driven");
  AST_STEP: assert property (s_drv_held |->
    led_on_current_ua - led_off_current_ua == mod_ua) else $error("step scaling wrong");
  AST_PCT: assert property (s_timing_held |->
    base_duty_pct_x100 == 14'((integration_duty_cycle * 625) >> 2)) else $error("duty percent");
  AST_QUAD_FLAG: assert property (s_timing_held |->
    timing_status.quad_period_too_low_error == (quad_period_count < QUAD_MIN))
    else $error("quad period flag wrong");
  AST_DUTY_FLAG: assert property (s_timing_held |->
    timing_status.duty_cycle_fit_error == (dead_cnt < DEAD_MIN)) else $error("duty fit flag wrong");
endmodule

bind idr_regs idr_properties #(.QUAD_MIN(QUAD_MIN), .DEAD_MIN(DEAD_MIN)) i_idr_properties (
  .sys_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .mod_gate, .drv_cfg, .led_on_current_ua,
  .led_off_current_ua, .illum_driver_output, .integration_duty_cycle, .base_duty_pct_x100,
  .quad_period_count, .timing_status
);

/* verification/testbench.sv */
// Self-checking bench for the illumination register bank
`timescale 1ns/10ps
module testbench;
  import idr_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [23:0] w;
    logic [23:0] r;
  } idr_row_s;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic mod_gate = 1'b0;
  logic [23:0] reg_rdata;
  logic [23:0] got;
  logic [17:0] su;
  idr_drv_cfg_s drv_cfg;
  idr_status_s timing_status;
  logic [17:0] on_ua, off_ua, drv_ua;
  logic [11:0] sup_duty;
  logic [13:0] pct;
  logic drv_en;
  logic [5:0] duty_out;
  logic [15:0] quad_out;
  int fail_count = 0;
  int cmp_count = 0;
  // Write then read back; flag rows assume the settings of the rows above them
  idr_row_s rows [12] = '{
    '{8'h3b, 24'h3fc000, 24'h3fc000}, '{8'h39, 24'h0000a0, 24'h0000a0},
    '{8'h3b, 24'h13c000, 24'h13c000}, '{8'h4f, 24'h000005, 24'h000005},
    '{8'h5c, 24'hffffff, 24'hfc0000}, '{8'h70, 24'h00003f, 24'h00003f},
    '{8'h50, 24'h000c32, 24'hc00c32}, '{8'h70, 24'h000040, 24'h000040},
    '{8'h50, 24'h000c32, 24'h800c32}, '{8'h5c, 24'h340000, 24'h340000},
    '{8'h50, 24'h000c32, 24'h000c32}, '{8'h00, 24'hffffff, 24'h000000}};

  idr_regs i_idr_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_gate(mod_gate),
    .drv_cfg(drv_cfg), .led_on_current_ua(on_ua), .led_off_current_ua(off_ua),
    .illum_driver_output(drv_ua), .led_driver_enable(drv_en), .integration_duty_cycle(duty_out),
    .supplementary_duty(sup_duty), .base_duty_pct_x100(pct), .quad_period_count(quad_out),
    .timing_status(timing_status)
  );

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_cur(input logic [17:0] g, input logic [17:0] e);
    chk_word({6'h0, g}, {6'h0, e});
  endtask

  // One-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [23:0] e);
    bus_rd(a, got);
    chk_word(got, e);
  endtask

  task automatic chk_resets;
    chk_rd(OFF_DRV, 24'h0);
    chk_word({23'h0, drv_en}, 24'h000000);
    chk_rd(OFF_SCALE, 24'h00003f);
    chk_rd(OFF_TSTAT, 24'h000c32);
    chk_word({22'h0, timing_status}, 24'h0);
    chk_word({12'h0, sup_duty}, 24'h000340);
  endtask

  // Hang guard, well beyond the roughly 120 cycles the run needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_resets();
    foreach (rows[i]) begin
      bus_wr(rows[i].a, rows[i].w);
      chk_rd(rows[i].a, rows[i].r);
    end
    // Scale 5, duty 13: 13 * 6 in 1/4096 units; 13 * 100 / 64 in 0.01 %
    chk_word({12'h0, sup_duty}, 24'h00004e);
    chk_word({10'h0, pct}, 24'd2031);
    chk_word({18'h0, duty_out}, 24'h00000d);
    chk_word({8'h0, quad_out}, 24'h000040);
    // Every step code with bias 10 and modulation 3
    for (int k = 0; k < 4; k++) begin
      su = 18'd5000 - 18'd1250 * 18'(k);
      bus_wr(OFF_DRV, {2'h0, 2'(k), 5'h03, 1'b1, 14'h0});
      mod_gate <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk_cur(on_ua, 18'(13 * su));
      chk_cur(off_ua, 18'(10 * su));
      chk_cur(drv_ua, 18'(13 * su));
      chk_word({23'h0, drv_en}, 24'h000001);
      @(posedge sys_clk);
      mod_gate <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk_cur(drv_ua, 18'(10 * su));
    end
    // Disabled driver stays dark even with the gate on
    bus_wr(OFF_DRV, 24'h138000);
    mod_gate <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_cur(drv_ua, 18'h0);
    chk_word({23'h0, drv_en}, 24'h000000);
    chk_word({16'h0, drv_cfg}, 24'h00004e);
    // Reset in mid-run; recheck the driver, scale, status and duty defaults (bias and quad not rechecked)
    @(posedge sys_clk);
    rst_n <= 1'b0;
    mod_gate <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_resets();
    give_verdict();
  end
endmodule
